//--- hw/ccs_sequencer.v
// charge cycle sequencer with ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ccs_consts.vh"
// Functional notes
// - good input needs headroom and UV/OV window
// - detect source type, pulse interrupt, start converter
// - new cycle needs all start conditions met
// - auto cycle when config 01, enable low
// - trickle charge below trickle threshold
// - trickle current select bit 185/145 mA
// - precharge until fast threshold, timeout fault
// - precharge current from four-bit field
// - constant current above fast threshold, six-bit
// - switch linear then fully on above margin
// - constant voltage at float voltage field
// - termination after 200ms deglitch when enabled
// - safety timer expiry ends cycle, fault
// - recharge after 200ms below recharge threshold
// - thermal threshold from two-bit field
// - min system voltage and tracking offset fields
// - suspended or done: switch off, regulate max
// - supplement mode when current zero, sys low
// - ideal diode on battery start or sys low
module ccs_sequencer #(
    parameter DEGLITCH_CYC = `CCS_DEGLITCH_MS * `CCS_CLK_MHZ * 1000,
    parameter [39:0] PRE_TIMEOUT_CYC =
        40'd`CCS_PRE_TIMEOUT_S * 40'd`CCS_CLK_MHZ * 40'd1000000,
    parameter [43:0] SAFETY_CYC = 44'd`CCS_SAFETY_H * 44'd3600 *
        44'd`CCS_CLK_MHZ * 44'd1000000
) (
    input wire SYS_CLK,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    input wire VIN_ABOVE_BATT_HDRM,
    input wire VIN_ABOVE_UVLO,
    input wire VIN_BELOW_OVLO,
    input wire SRC_DET_DONE,
    input wire [2:0] SRC_DET_TYPE,
    input wire CHARGE_ENABLE_N,
    input wire THERMISTOR_FAULT,
    input wire VBATT_BELOW_TRICKLE,
    input wire VBATT_ABOVE_FAST,
    input wire VBATT_ABOVE_SYS_GOOD,
    input wire VBATT_AT_FLOAT,
    input wire ICHG_AT_TERM,
    input wire VBATT_BELOW_RECHG,
    input wire VBATT_BELOW_SYS_MIN,
    input wire VSYS_BELOW_VBATT,
    input wire ICHG_LIMITED_ZERO,
    input wire VIN_FROM_BATTERY,
    output reg INT_PULSE,
    output reg INPUT_GOOD,
    output reg SRC_DET_START,
    output reg CONVERTER_ON,
    output reg CHARGE_ON,
    output reg [4:0] CHARGE_PHASE,
    output reg TRICKLE_HIGH,
    output reg [3:0] PRECHARGE_CURRENT,
    output reg [5:0] FAST_CURRENT,
    output reg FAST_THRESHOLD_SEL,
    output reg [6:0] FLOAT_VOLTAGE,
    output reg [3:0] TERM_CURRENT,
    output reg [1:0] THERMAL_THRESHOLD,
    output reg [2:0] MIN_SYSTEM_VOLTAGE,
    output reg TRACK_OFFSET,
    output reg BATTERY_SWITCH_ON,
    output reg BATTERY_SWITCH_LINEAR,
    output reg SYS_REG_AT_MAX,
    output reg SUPPLEMENT_MODE,
    output reg IDEAL_DIODE
);
    // one-hot phases
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_TRICKLE = 7'h02;
    localparam [6:0] ST_PRE = 7'h04;
    localparam [6:0] ST_CC = 7'h08;
    localparam [6:0] ST_CV = 7'h10;
    localparam [6:0] ST_DONE = 7'h20;
    localparam [6:0] ST_FAULT = 7'h40;
    localparam [6:0] ST_ACTIVE = ST_TRICKLE | ST_PRE | ST_CC | ST_CV;
    localparam [2:0] IN_WAIT = 3'h1;
    localparam [2:0] IN_DET = 3'h2;
    localparam [2:0] IN_RUN = 3'h4;

    // ctrl: [1:0] cfg, [2] switch forced off, [3] term en,
    // [4] trickle sel, [6:5] thermal, [9:7] sys min, [10] track,
    // [11] fast threshold sel, [12] fault clear (self clearing)
    reg [31:0] ctrl_r;
    reg [31:0] curr_r;
    reg [31:0] volt_r;
    reg [31:0] rdata_r;
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    reg [6:0] st_r;
    reg [6:0] st_nxt;
    reg [2:0] in_r;
    reg [2:0] src_type_r;
    reg pre_fault_r;
    reg safe_fault_r;
    reg [43:0] tmr_r;
    reg [31:0] dg_r;
    reg int_nxt;

    // control fields
    wire [1:0] cfg_f = ctrl_r[`CCS_CTRL_CFG];
    wire sw_off_f = ctrl_r[`CCS_CTRL_SWOFF];
    wire term_en_f = ctrl_r[`CCS_CTRL_TERM];
    wire trickle_f = ctrl_r[`CCS_CTRL_TRICKLE];
    wire [1:0] thermal_f = ctrl_r[`CCS_CTRL_THERMAL];
    wire [2:0] sys_min_f = ctrl_r[`CCS_CTRL_SYSMIN];
    wire track_f = ctrl_r[`CCS_CTRL_TRACK];
    wire fast_sel_f = ctrl_r[`CCS_CTRL_FASTSEL];
    // current and voltage fields
    wire [3:0] pre_i_f = curr_r[`CCS_CURR_PRE];
    wire [5:0] fast_i_f = curr_r[`CCS_CURR_FAST];
    wire [3:0] term_i_f = curr_r[`CCS_CURR_TERM];
    wire [6:0] float_f = volt_r[`CCS_VOLT_FLOAT];
    // status word as software reads it
    wire [31:0] stat_w = {17'h0, src_type_r, safe_fault_r,
        pre_fault_r, in_r, st_r};

    wire good_in = VIN_ABOVE_BATT_HDRM & VIN_ABOVE_UVLO & VIN_BELOW_OVLO;
    wire fault_clr = wr_pend_r & (wr_addr_r == `CCS_A_CTRL) &
        HWDATA[`CCS_CTRL_FCLR];
    // each start condition apart so a suspend is easy to trace
    wire cfg_auto = cfg_f == `CCS_CFG_AUTO;
    wire pin_en = ~CHARGE_ENABLE_N;
    wire no_fault = ~THERMISTOR_FAULT & ~safe_fault_r & ~pre_fault_r;
    wire may_start = (in_r == IN_RUN) & good_in &
        cfg_auto & pin_en &
        no_fault & ~sw_off_f;
    wire dg_full = (dg_r == DEGLITCH_CYC);

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_r;

    // bus slave: writes land in the data phase, reads answer next cycle
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            ctrl_r <= `CCS_CTRL_RST;
            curr_r <= `CCS_CURR_RST;
            volt_r <= `CCS_VOLT_RST;
        end else begin
            wr_pend_r <= HSEL & HREADY & HTRANS[1] & HWRITE;
            wr_addr_r <= HADDR[7:0];
            if (wr_pend_r) begin
                case (wr_addr_r)
                    `CCS_A_CTRL: ctrl_r <= {19'h0, 1'b0, HWDATA[11:0]};
                    `CCS_A_CURR: curr_r <= {18'h0, HWDATA[13:0]};
                    `CCS_A_VOLT: volt_r <= {21'h0, HWDATA[10:0]};
                    default: ;
                endcase
            end
        end
    end

    // read mux registered so hrdata stands through the data phase
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= 32'h0000_0000;
        end else if (HSEL & HREADY & HTRANS[1] & ~HWRITE) begin
            case (HADDR[7:0])
                `CCS_A_CTRL: rdata_r <= ctrl_r;
                `CCS_A_CURR: rdata_r <= curr_r;
                `CCS_A_VOLT: rdata_r <= volt_r;
                `CCS_A_STAT: rdata_r <= stat_w;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // input qualification and source detection
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            in_r <= IN_WAIT;
        end else begin
            case (in_r)
                IN_WAIT: if (good_in) in_r <= IN_DET;
                IN_DET: begin
                    if (!good_in) begin
                        in_r <= IN_WAIT;
                    end else if (SRC_DET_DONE) begin
                        in_r <= IN_RUN;
                    end
                end
                IN_RUN: if (!good_in) in_r <= IN_WAIT;
                default: in_r <= IN_WAIT;
            endcase
        end
    end

    // source type latches only on a completed detection
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            src_type_r <= 3'h0;
        end else if ((in_r == IN_DET) & good_in & SRC_DET_DONE) begin
            src_type_r <= SRC_DET_TYPE;
        end
    end

    always @* begin
        st_nxt = st_r;
        case (st_r)
            // a battery that is already charged skips straight to cc
            ST_IDLE: if (may_start) begin
                st_nxt = VBATT_BELOW_TRICKLE ? ST_TRICKLE : ST_PRE;
                if (VBATT_ABOVE_FAST) st_nxt = ST_CC;
            end
            ST_TRICKLE: if (!VBATT_BELOW_TRICKLE) st_nxt = ST_PRE;
            ST_PRE: begin
                if (VBATT_ABOVE_FAST) st_nxt = ST_CC;
                else if (tmr_r >= PRE_TIMEOUT_CYC) st_nxt = ST_FAULT;
            end
            ST_CC: begin
                if (VBATT_AT_FLOAT) st_nxt = ST_CV;
                else if (tmr_r >= SAFETY_CYC) st_nxt = ST_FAULT;
            end
            ST_CV: begin
                if (term_en_f & ICHG_AT_TERM & dg_full) st_nxt = ST_DONE;
                else if (tmr_r >= SAFETY_CYC) st_nxt = ST_FAULT;
            end
            ST_DONE: if (VBATT_BELOW_RECHG & dg_full) st_nxt = ST_IDLE;
            ST_FAULT: if (fault_clr) st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
        // dropping any start condition suspends the cycle
        if (!may_start && (st_r & ST_ACTIVE) != 7'h00)
            st_nxt = ST_IDLE;
    end

    // interrupt sources; each is a single-cycle event
    always @* begin
        int_nxt = ((in_r == IN_WAIT) & good_in) |
            ((in_r == IN_DET) & good_in & SRC_DET_DONE) |
            ((st_nxt == ST_FAULT) & (st_r != ST_FAULT));
    end

    // sequencer state and interrupt pulse
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st_r <= ST_IDLE;
            INT_PULSE <= 1'b0;
        end else begin
            st_r <= st_nxt;
            INT_PULSE <= int_nxt;
        end
    end

    // pre timer restarts at each phase, safety spans cc and cv;
    // one counter serves both because the phases never overlap
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            tmr_r <= 44'h000_0000_0000;
        end else if (st_nxt == ST_CV || st_nxt == st_r) begin
            tmr_r <= tmr_r + 44'h000_0000_0001;
        end else begin
            tmr_r <= 44'h000_0000_0000;
        end
    end

    // one deglitch counter for termination and recharge; it saturates
    // so a long hold cannot wrap back below the threshold
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            dg_r <= 32'h0000_0000;
        end else if (((st_r == ST_CV) & ICHG_AT_TERM) |
            ((st_r == ST_DONE) & VBATT_BELOW_RECHG)) begin
            if (!dg_full) dg_r <= dg_r + 32'h0000_0001;
        end else begin
            dg_r <= 32'h0000_0000;
        end
    end

    // timeout flags: a new fault wins over a clear in the same cycle
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pre_fault_r <= 1'b0;
            safe_fault_r <= 1'b0;
        end else begin
            if (st_r == ST_PRE && st_nxt == ST_FAULT)
                pre_fault_r <= 1'b1;
            else if (fault_clr)
                pre_fault_r <= 1'b0;
            if ((st_r == ST_CC || st_r == ST_CV) && st_nxt == ST_FAULT)
                safe_fault_r <= 1'b1;
            else if (fault_clr)
                safe_fault_r <= 1'b0;
        end
    end

    // status outputs follow the sequencer one cycle later
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            INPUT_GOOD <= 1'b0;
            SRC_DET_START <= 1'b0;
            CONVERTER_ON <= 1'b0;
            CHARGE_ON <= 1'b0;
            CHARGE_PHASE <= 5'h00;
        end else begin
            INPUT_GOOD <= good_in;
            SRC_DET_START <= in_r == IN_DET;
            CONVERTER_ON <= in_r == IN_RUN;
            CHARGE_ON <= (st_r & ST_ACTIVE) != 7'h00;
            CHARGE_PHASE <= st_r[4:0];
        end
    end

    // analog settings: host rewrites reach the loops on the next edge
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            TRICKLE_HIGH <= 1'b0;
            PRECHARGE_CURRENT <= 4'h0;
            FAST_CURRENT <= 6'h00;
            FAST_THRESHOLD_SEL <= 1'b0;
            FLOAT_VOLTAGE <= 7'h00;
            TERM_CURRENT <= 4'h0;
            THERMAL_THRESHOLD <= 2'h0;
            MIN_SYSTEM_VOLTAGE <= 3'h0;
            TRACK_OFFSET <= 1'b0;
        end else begin
            TRICKLE_HIGH <= trickle_f;
            PRECHARGE_CURRENT <= pre_i_f;
            FAST_CURRENT <= fast_i_f;
            FAST_THRESHOLD_SEL <= fast_sel_f;
            FLOAT_VOLTAGE <= float_f;
            TERM_CURRENT <= term_i_f;
            THERMAL_THRESHOLD <= thermal_f;
            MIN_SYSTEM_VOLTAGE <= sys_min_f;
            TRACK_OFFSET <= track_f;
        end
    end

    // power path; the switch stays linear until the battery clears
    // minimum system voltage plus the good margin
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            BATTERY_SWITCH_ON <= 1'b0;
            BATTERY_SWITCH_LINEAR <= 1'b0;
            SYS_REG_AT_MAX <= 1'b0;
            SUPPLEMENT_MODE <= 1'b0;
            IDEAL_DIODE <= 1'b0;
        end else begin
            BATTERY_SWITCH_ON <= (st_r == ST_CC | st_r == ST_CV) &
                VBATT_ABOVE_SYS_GOOD;
            BATTERY_SWITCH_LINEAR <= (st_r == ST_TRICKLE) |
                (st_r == ST_PRE) | ((st_r == ST_CC) &
                ~VBATT_ABOVE_SYS_GOOD);
            SYS_REG_AT_MAX <= (st_r == ST_IDLE) | (st_r == ST_DONE) |
                (st_r == ST_FAULT);
            SUPPLEMENT_MODE <= ICHG_LIMITED_ZERO & VSYS_BELOW_VBATT;
            IDEAL_DIODE <= VIN_FROM_BATTERY |
                (VBATT_BELOW_SYS_MIN & VSYS_BELOW_VBATT);
        end
    end
endmodule

//--- hw/ccs_consts.vh
// constants for the charge cycle sequencer
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH
`define CCS_A_CTRL 8'h00
`define CCS_A_CURR 8'h04
`define CCS_A_VOLT 8'h08
`define CCS_A_TIME 8'h0C
`define CCS_A_STAT 8'h10
`define CCS_A_LIM 8'h14
`define CCS_CFG_AUTO 2'h1
`define CCS_CTRL_CFG 1:0
`define CCS_CTRL_SWOFF 2
`define CCS_CTRL_TERM 3
`define CCS_CTRL_TRICKLE 4
`define CCS_CTRL_THERMAL 6:5
`define CCS_CTRL_SYSMIN 9:7
`define CCS_CTRL_TRACK 10
`define CCS_CTRL_FASTSEL 11
`define CCS_CTRL_FCLR 12
`define CCS_CURR_PRE 3:0
`define CCS_CURR_FAST 9:4
`define CCS_CURR_TERM 13:10
`define CCS_VOLT_FLOAT 6:0
`define CCS_CTRL_RST 32'h0000_0191
`define CCS_CURR_RST 32'h0000_0000
`define CCS_VOLT_RST 32'h0000_0000
`define CCS_LIM_RST 32'h0000_0000
`define CCS_CLK_MHZ 250
`define CCS_DEGLITCH_MS 200
`define CCS_PRE_TIMEOUT_S 3600
`define CCS_SAFETY_H 10
`define CCS_HTRANS_NONSEQ 2'h2
`endif

//--- verification/ccs_checker.sv
// port assertions for the charge cycle sequencer
`timescale 1ns/1ps
module ccs_checker (
    input wire SYS_CLK,
    input wire RST,
    input wire HREADYOUT,
    input wire HRESP,
    input wire VIN_ABOVE_BATT_HDRM,
    input wire VIN_ABOVE_UVLO,
    input wire VIN_BELOW_OVLO,
    input wire INT_PULSE,
    input wire INPUT_GOOD,
    input wire SRC_DET_START,
    input wire CONVERTER_ON,
    input wire CHARGE_ON,
    input wire [4:0] CHARGE_PHASE,
    input wire BATTERY_SWITCH_ON,
    input wire SYS_REG_AT_MAX,
    input wire ICHG_LIMITED_ZERO,
    input wire VSYS_BELOW_VBATT,
    input wire SUPPLEMENT_MODE,
    input wire VIN_FROM_BATTERY,
    input wire IDEAL_DIODE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_bus_no_wait: assert property (HREADYOUT && !HRESP)
        else $error("bus stalled or errored");
    a_input_good: assert property (##1 INPUT_GOOD ==
        $past(VIN_ABOVE_BATT_HDRM && VIN_ABOVE_UVLO && VIN_BELOW_OVLO))
        else $error("input good does not follow qualification");
    a_good_irq: assert property ($rose(INPUT_GOOD) |->
        INT_PULSE ##1 SRC_DET_START)
        else $error("no interrupt or detection on good input");
    a_conv_after_det: assert property ($rose(CONVERTER_ON) |->
        $past(INT_PULSE))
        else $error("converter started without detection interrupt");
    a_irq_pulse: assert property (INT_PULSE |=> !INT_PULSE)
        else $error("interrupt longer than one cycle");
    a_phase_onehot: assert property ($onehot0(CHARGE_PHASE))
        else $error("charge phase not one-hot");
    a_idle_switch: assert property (!CHARGE_ON [*3] |->
        !BATTERY_SWITCH_ON && SYS_REG_AT_MAX)
        else $error("switch on or system low while not charging");
    a_supplement: assert property (ICHG_LIMITED_ZERO &&
        VSYS_BELOW_VBATT |=> SUPPLEMENT_MODE)
        else $error("supplement mode not entered");
    a_ideal_diode: assert property (VIN_FROM_BATTERY |=> IDEAL_DIODE)
        else $error("ideal diode not entered");
    c_cv: cover property (CHARGE_PHASE == 5'h10);
    c_cc: cover property (CHARGE_PHASE == 5'h08 && BATTERY_SWITCH_ON);
    c_conv: cover property ($rose(CONVERTER_ON));
endmodule

//--- verification/ccs_batt_model.sv
// battery and charge path model driving the sequencer level inputs
`timescale 1ns/1ps
module ccs_batt_model (
    input wire clk,
    input wire rst,
    input wire charge_on,
    input wire hold,
    input wire drain,
    output wire below_trickle,
    output wire above_fast,
    output wire above_sys_good,
    output wire below_sys_min,
    output wire at_float,
    output wire at_term,
    output wire below_rechg
);
    // coarse ladder: 0 deep, 1 pre, 2 fast, 3 good, 4 float, 5 full
    reg [2:0] lvl_r;
    reg [2:0] cnt_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_r <= 3'h0;
            cnt_r <= 3'h0;
        end else if (drain) begin
            lvl_r <= 3'h1;
        end else if (charge_on && !hold) begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7 && lvl_r < 3'h5)
                lvl_r <= lvl_r + 3'h1;
        end
    end
    assign below_trickle = lvl_r == 3'h0;
    assign above_fast = lvl_r >= 3'h2;
    assign above_sys_good = lvl_r >= 3'h3;
    assign below_sys_min = lvl_r < 3'h3;
    assign at_float = lvl_r >= 3'h4;
    assign at_term = lvl_r == 3'h5;
    assign below_rechg = lvl_r < 3'h4;
endmodule

//--- verification/charge_cycle_sequencer_tb_top.sv
// top bench for the charge cycle sequencer
`timescale 1ns/1ps
`include "ccs_consts.vh"
module charge_cycle_sequencer_tb_top;
    logic SYS_CLK = 0, RST = 1, HSEL = 1, HWRITE = 0, HOLD = 1, DRAIN = 0;
    logic [31:0] HADDR = 0, HWDATA = 0;
    logic [1:0] HTRANS = 0;
    logic [2:0] HSIZE = 3'h2, SRC_DET_TYPE = 0;
    logic VIN_ABOVE_BATT_HDRM = 0, VIN_ABOVE_UVLO = 0, VIN_BELOW_OVLO = 0;
    logic SRC_DET_DONE = 0, CHARGE_ENABLE_N = 0, THERMISTOR_FAULT = 0;
    logic ICHG_LIMITED_ZERO = 0, VSYS_BELOW_VBATT = 0, VIN_FROM_BATTERY = 0;
    wire HREADY, HREADYOUT, HRESP, INT_PULSE, INPUT_GOOD, SRC_DET_START;
    wire CONVERTER_ON, CHARGE_ON, TRICKLE_HIGH, FAST_THRESHOLD_SEL;
    wire TRACK_OFFSET, BATTERY_SWITCH_ON, BATTERY_SWITCH_LINEAR;
    wire SYS_REG_AT_MAX, SUPPLEMENT_MODE, IDEAL_DIODE, VBATT_BELOW_TRICKLE;
    wire VBATT_ABOVE_FAST, VBATT_ABOVE_SYS_GOOD, VBATT_AT_FLOAT, ICHG_AT_TERM;
    wire VBATT_BELOW_RECHG, VBATT_BELOW_SYS_MIN;
    wire [31:0] HRDATA;
    wire [4:0] CHARGE_PHASE;
    wire [3:0] PRECHARGE_CURRENT, TERM_CURRENT;
    wire [5:0] FAST_CURRENT;
    wire [6:0] FLOAT_VOLTAGE;
    wire [1:0] THERMAL_THRESHOLD;
    wire [2:0] MIN_SYSTEM_VOLTAGE;
    wire [31:0] ctrl_o = {24'h0, FAST_THRESHOLD_SEL, TRACK_OFFSET,
        MIN_SYSTEM_VOLTAGE, THERMAL_THRESHOLD, TRICKLE_HIGH};
    wire [31:0] curr_o = {18'h0, TERM_CURRENT, FAST_CURRENT, PRECHARGE_CURRENT};
    int num_errors = 0, num_checks = 0, n_int = 0, k;
    assign HREADY = HREADYOUT;
    always #2 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (INT_PULSE === 1'b1) n_int <= n_int + 1;
    ccs_sequencer #(.DEGLITCH_CYC(20), .PRE_TIMEOUT_CYC(40'd100),
        .SAFETY_CYC(44'd200)) i_ccs_sequencer (.*);
    ccs_batt_model i_ccs_batt_model (.clk(SYS_CLK), .rst(RST),
        .charge_on(CHARGE_ON), .hold(HOLD), .drain(DRAIN),
        .below_trickle(VBATT_BELOW_TRICKLE), .above_fast(VBATT_ABOVE_FAST),
        .above_sys_good(VBATT_ABOVE_SYS_GOOD),
        .below_sys_min(VBATT_BELOW_SYS_MIN), .at_float(VBATT_AT_FLOAT),
        .at_term(ICHG_AT_TERM), .below_rechg(VBATT_BELOW_RECHG));
    task finish_test;
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task ahb(input [31:0] a, input w, input [31:0] d, output [31:0] r);
        HADDR <= a;
        HWRITE <= w;
        HTRANS <= `CCS_HTRANS_NONSEQ;
        @(posedge SYS_CLK);
        while (HREADY !== 1'b1) @(posedge SYS_CLK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge SYS_CLK);
        while (HREADY !== 1'b1) @(posedge SYS_CLK);
        r = HRDATA;
    endtask
    task wr(input [31:0] a, input [31:0] d);
        logic [31:0] r;
        ahb(a, 1'b1, d, r);
    endtask
    task rd(input [31:0] a, input [31:0] exp);
        logic [31:0] r;
        ahb(a, 1'b0, 32'h0, r);
        chk("hrdata", exp, r);
    endtask
    task wait_ph(input [4:0] p);
        int i;
        for (i = 0; i < 400 && CHARGE_PHASE !== p; i++) @(posedge SYS_CLK);
        chk("phase", {27'h0, p}, {27'h0, CHARGE_PHASE});
    endtask
    task setc(input int c, input logic on);
        case (c)
            0: CHARGE_ENABLE_N <= on;
            1: THERMISTOR_FAULT <= on;
            2: wr(`CCS_A_CTRL, on ? 32'h0000_0EC8 : 32'h0000_0EC9);
            default: wr(`CCS_A_CTRL, on ? 32'h0000_0ECD : 32'h0000_0EC9);
        endcase
        @(posedge SYS_CLK);
    endtask
    // stall the battery in phase p until a timer fault, then clear it
    task fault_case(input [4:0] p, input [31:0] stat);
        int n0;
        wait_ph(p);
        HOLD <= 1'b1;
        n0 = n_int;
        wait_ph(5'h00);
        repeat (3) @(posedge SYS_CLK);
        chk("int count", n0 + 1, n_int);
        rd(`CCS_A_STAT, stat);
        wr(`CCS_A_CTRL, 32'h0000_1EC9);
        HOLD <= 1'b0;
    endtask
    // whole run is several hundred cycles; this limit only catches hangs
    initial begin
        #80000;
        num_errors++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        rd(`CCS_A_CTRL, `CCS_CTRL_RST);
        rd(`CCS_A_CURR, `CCS_CURR_RST);
        rd(32'h1C, 32'h0);
        chk("ctrl out", 32'h19, ctrl_o);
        wr(`CCS_A_CURR, 32'h0000_0EA5);
        wr(`CCS_A_VOLT, 32'h0000_0055);
        wr(`CCS_A_CTRL, 32'h0000_0EC9);
        wr(32'h1C, 32'hFFFF_FFFF);
        rd(`CCS_A_CTRL, 32'h0000_0EC9);
        chk("curr out", 32'hEA5, curr_o);
        chk("float", 32'h55, {25'h0, FLOAT_VOLTAGE});
        chk("ctrl out", 32'hEC, ctrl_o);
        VIN_ABOVE_BATT_HDRM <= 1'b1;
        VIN_ABOVE_UVLO <= 1'b1;
        VIN_BELOW_OVLO <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        chk("good", 32'h6, {INPUT_GOOD, SRC_DET_START, CONVERTER_ON});
        SRC_DET_TYPE <= 3'h5;
        SRC_DET_DONE <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        SRC_DET_DONE <= 1'b0;
        chk("detect", 32'h5, {INPUT_GOOD, SRC_DET_START, CONVERTER_ON});
        chk("int count", 32'h2, n_int);
        wait_ph(5'h02);
        for (k = 0; k < 4; k++) begin
            setc(k, 1'b1);
            wait_ph(5'h01);
            setc(k, 1'b0);
            wait_ph(5'h02);
        end
        HOLD <= 1'b0;
        wait_ph(5'h04);
        wait_ph(5'h08);
        repeat (2) @(posedge SYS_CLK);
        chk("linear", 32'h2, {BATTERY_SWITCH_LINEAR, BATTERY_SWITCH_ON});
        wr(`CCS_A_CURR, 32'h0000_0FF5);
        repeat (8) @(posedge SYS_CLK);
        chk("curr out", 32'hFF5, curr_o);
        chk("full on", 32'h1, {BATTERY_SWITCH_LINEAR, BATTERY_SWITCH_ON});
        wait_ph(5'h10);
        wait_ph(5'h00);
        repeat (3) @(posedge SYS_CLK);
        chk("done", 32'h1, {CHARGE_ON, BATTERY_SWITCH_ON, SYS_REG_AT_MAX});
        DRAIN <= 1'b1;
        HOLD <= 1'b1;
        @(posedge SYS_CLK);
        DRAIN <= 1'b0;
        repeat (10) @(posedge SYS_CLK);
        chk("deglitch", 32'h0, {31'h0, CHARGE_ON});
        fault_case(5'h04, 32'h0000_5640);
        fault_case(5'h08, 32'h0000_5A40);
        ICHG_LIMITED_ZERO <= 1'b1;
        VSYS_BELOW_VBATT <= 1'b1;
        VIN_FROM_BATTERY <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        chk("path", 32'h3, {SUPPLEMENT_MODE, IDEAL_DIODE});
        finish_test;
    end
endmodule
bind ccs_sequencer ccs_checker i_ccs_checker (.*);
